// ===== common/dmp_pkg.sv
// Package of constants and types for the dual modulus prescaler
package dmp_pkg;

  // ****************************************
  // Ratio variants
  // ****************************************
  typedef enum logic [1:0] {
    DMP_DIV_40_41 = 2'h0,
    DMP_DIV_64_65 = 2'h1,
    DMP_DIV_80_81 = 2'h2
  } dmp_variant_t;

  localparam int unsigned RATIO_LOW_40 = 40;
  localparam int unsigned RATIO_LOW_64 = 64;
  localparam int unsigned RATIO_LOW_80 = 80;

  // Widest count needed: 81 input edges
  localparam int unsigned CNT_W = 7;

  // ****************************************
  // Reset values
  // ****************************************
  // Divide by N after reset, matching a released control input
  localparam logic MOD_RST = 1'h1;
  localparam logic [CNT_W-1:0] CNT_RST = 7'h00;
  localparam logic DIV_RST = 1'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SYNC_STAGES = 2;

  function automatic int unsigned dmp_low_ratio(input dmp_variant_t v);
    int unsigned r;
    r = RATIO_LOW_64;
    unique case (v)
      DMP_DIV_40_41: r = RATIO_LOW_40;
      DMP_DIV_64_65: r = RATIO_LOW_64;
      DMP_DIV_80_81: r = RATIO_LOW_80;
      default: r = RATIO_LOW_64;
    endcase
    return r;
  endfunction

endpackage

// ===== src/dmp_sync_edge.sv
// Two stage pin synchroniser with rising edge detector
module dmp_sync_edge (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic prev_q;
  logic prev_d;

  always_comb begin
    meta_d = pin_i;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      prev_q <= 1'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;

endmodule

// ===== src/dmp_prescaler.sv
// Dual modulus prescaler dividing a sampled input clock by N or N+1
module dmp_prescaler #(
  parameter dmp_pkg::dmp_variant_t VARIANT = dmp_pkg::DMP_DIV_64_65
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic fin_i,
  input wire logic mod_ctrl_i,
  output logic div_o,
  output logic mod_low_o
);

  // ****************************************
  // Ratio set
  // ****************************************
  localparam int unsigned RATIO_N = dmp_pkg::dmp_low_ratio(VARIANT);
  localparam logic [dmp_pkg::CNT_W-1:0] TERM_N = dmp_pkg::CNT_W'(RATIO_N - 1);
  localparam logic [dmp_pkg::CNT_W-1:0] TERM_N1 = dmp_pkg::CNT_W'(RATIO_N);
  localparam logic [dmp_pkg::CNT_W-1:0] HALF_N = dmp_pkg::CNT_W'(RATIO_N / 2);

  // ****************************************
  // Pin sampling
  // ****************************************
  logic fin_rise;
  logic ctrl_lvl;

  dmp_sync_edge u_fin_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .pin_i(fin_i),
    .level_o(),
    .rise_o(fin_rise)
  );

  // Same depth as the clock path, so the control keeps its setup margin
  // relative to the input edge once both are resampled
  dmp_sync_edge u_ctrl_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .pin_i(mod_ctrl_i),
    .level_o(ctrl_lvl),
    .rise_o()
  );

  // ****************************************
  // Counter
  // ****************************************
  logic [dmp_pkg::CNT_W-1:0] cnt_q;
  logic [dmp_pkg::CNT_W-1:0] cnt_d;
  logic mod_q;
  logic mod_d;
  logic div_q;
  logic div_d;
  logic [dmp_pkg::CNT_W-1:0] term;
  logic wrap;

  always_comb begin
    term = mod_q ? TERM_N : TERM_N1;
    wrap = fin_rise && (cnt_q == term);
    cnt_d = cnt_q;
    mod_d = mod_q;
    if (fin_rise) begin
      if (wrap) begin
        cnt_d = dmp_pkg::CNT_RST;
        // Modulus only changes at a count boundary
        mod_d = ctrl_lvl;
      end else begin
        cnt_d = cnt_q + 7'h01;
      end
    end
    // Output rises at the start of each count, one period per count
    div_d = (cnt_d < HALF_N);
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= dmp_pkg::CNT_RST;
      mod_q <= dmp_pkg::MOD_RST;
      div_q <= dmp_pkg::DIV_RST;
    end else begin
      cnt_q <= cnt_d;
      mod_q <= mod_d;
      div_q <= div_d;
    end
  end

  assign div_o = div_q;
  assign mod_low_o = mod_q;

  // ****************************************
  // Assertions
  // ****************************************
  localparam int CTRL_LAT = dmp_pkg::SYNC_STAGES;

  ratio_pair_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (RATIO_N == 40) || (RATIO_N == 64) || (RATIO_N == 80))
    else $error("Ratio outside the three variants");

  sequence wrap_s;
    fin_rise && (cnt_q == term);
  endsequence

  low_ratio_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (wrap_s and ctrl_lvl) |=> (mod_q && (term == 7'(RATIO_N - 1))))
    else $error("Control high did not select divide by N");

  high_ratio_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (wrap_s and !ctrl_lvl) |=> (!mod_q && (term == 7'(RATIO_N))))
    else $error("Control low did not select divide by N+1");

  ctrl_sample_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wrap_s |=> (mod_q == $past(mod_ctrl_i, CTRL_LAT + 1)))
    else $error("Modulus not taken from control at the input edge");

  mod_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !(fin_rise && (cnt_q == term)) |=> $stable(mod_q))
    else $error("Modulus changed inside a count");

  cnt_bound_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    cnt_q <= term)
    else $error("Count ran past the terminal value");

  out_rise_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(div_q) |-> ((cnt_q == 7'h00) && $past(fin_rise)))
    else $error("Output rose away from a count boundary");

  out_fall_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $fell(div_q) |-> ((cnt_q == HALF_N) && $past(fin_rise)))
    else $error("Output fell away from mid count");

  // ****************************************
  // Pin to count latency
  // ****************************************
  // Both pins see the same two stage delay; a skew here would eat
  // into the setup margin that the loop logic budgets for
  sequence fin_edge_s;
    !fin_i ##1 fin_i;
  endsequence

  sequence ctrl_rise_s;
    !mod_ctrl_i ##1 mod_ctrl_i;
  endsequence

  sequence ctrl_fall_s;
    mod_ctrl_i ##1 !mod_ctrl_i;
  endsequence

  rise_lat_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    fin_edge_s |-> ##2 fin_rise)
    else $error("Input edge not seen two cycles after sampling");

  rise_single_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    fin_rise |=> !fin_rise)
    else $error("One input edge counted twice");

  ctrl_set_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ctrl_rise_s |-> ##2 ctrl_lvl)
    else $error("Rising control not seen two cycles after sampling");

  ctrl_clear_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ctrl_fall_s |-> ##2 !ctrl_lvl)
    else $error("Falling control not seen two cycles after sampling");

  // ****************************************
  // Count progress
  // ****************************************
  cnt_step_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (fin_rise && !wrap) |=> (cnt_q == $past(cnt_q) + 7'h01))
    else $error("Count did not advance on an input edge");

  cnt_idle_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !fin_rise |=> $stable(cnt_q))
    else $error("Count moved without an input edge");

  cnt_clear_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wrap_s |=> (cnt_q == dmp_pkg::CNT_RST))
    else $error("Count not cleared at the terminal edge");

  short_wrap_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (fin_rise && mod_q && (cnt_q == TERM_N)) |=> (cnt_q == dmp_pkg::CNT_RST))
    else $error("Divide by N count did not end after N edges");

  long_run_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (fin_rise && !mod_q && (cnt_q == TERM_N)) |=> (cnt_q == TERM_N1))
    else $error("Divide by N+1 count ended after N edges");

  mod_load_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wrap_s |=> (mod_low_o == $past(ctrl_lvl)))
    else $error("Modulus output not loaded from sampled control");

  // ****************************************
  // Output shape
  // ****************************************
  div_start_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wrap_s |=> div_o)
    else $error("Output not high at the start of a count");

  div_idle_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !fin_rise |=> $stable(div_o))
    else $error("Output moved without an input edge");

  div_drop_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (fin_rise && (cnt_q == HALF_N - 7'h01)) |=> !div_o)
    else $error("Output did not fall at mid count");

  div_keep_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (fin_rise && !wrap && (cnt_q < HALF_N - 7'h01)) |=> div_o)
    else $error("Output fell before mid count");

endmodule

// ===== tb/dmp_loop_model.sv
// Loop counter logic model feeding the prescaler
module dmp_loop_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ctrl_i,
  output logic fin_o,
  output logic mod_ctrl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q = 2'h0;
  initial fin_o = 1'h0;
  // Bench changes control just after a count starts, far ahead of its end
  assign mod_ctrl_o = ctrl_i;
  // Uneven phases: 2 high, 3 low, so the sampler sees every edge
  always @(negedge sys_clk_i) begin
    if (!nrst_i) begin
      cnt_q <= 2'h0;
    end else if (cnt_q >= {1'h0, !fin_o} + 2'h1) begin
      fin_o <= !fin_o;
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule

// ===== tb/tb_top.sv
// Testbench counting input edges per divided output period
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 40;
  logic sys_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic ctrl = 1'h1;
  logic fin, modc, div_o, mod_low_o;
  logic fin_p = 1'h0;
  logic div_p = 1'h1;
  int err_total = 0;
  int cmp_count = 0;
  int rises = 0;
  int ndiv = 0;
  logic exp_q[$] = '{1'h1};
  logic [31:0] seed = 32'hd80cf095;

  dmp_loop_model i_loop (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ctrl_i(ctrl), .fin_o(fin), .mod_ctrl_o(modc));
  dmp_prescaler #(.VARIANT(dmp_pkg::DMP_DIV_40_41)) i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .fin_i(fin),
    .mod_ctrl_i(modc), .div_o(div_o), .mod_low_o(mod_low_o));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    forever #2.5 sys_clk_i = !sys_clk_i;
  end

  // ****************************************
  // Reference model, sampled on falling edges
  // ****************************************
  always @(negedge sys_clk_i) begin
    if (nrst_i) begin
      if (fin === 1'h1 && fin_p === 1'h0) rises++;
      fin_p = fin;
      // Periods timed from the output's rising edge
      if (div_o === 1'h1 && div_p === 1'h0) begin
        if (ndiv > 0) check(32'(rises), exp_q.pop_front() ? 32'(N) : 32'(N + 1));
        check({31'h0, mod_low_o}, {31'h0, exp_q[0]});
        rises = 0;
        ndiv++;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        ctrl = seed[0];
        exp_q.push_back(seed[0]);
      end
      // High phase spans the first N/2 edges of every count, for N and N+1 alike
      if (div_o === 1'h0 && div_p === 1'h1) check(32'(rises), 32'(N / 2));
      div_p = div_o;
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    nrst_i = 1'h1;
    wait (ndiv == 30);
    print_verdict();
  end

  // About 30 periods of 41 edges at 5 cycles each, with wide margin
  initial begin
    #100us;
    err_total++;
    print_verdict();
  end
endmodule
